// [core/wdd_exec.v]
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`include "wdd_map.vh"
`default_nettype none

// Function
// - watchdog clear instruction loads the watchdog counter with zero.
// - watchdog clear also zeroes the watchdog prescaler count.
// - watchdog clear sets timeout and powerdown flags to one, nothing else.
// - watchdog clear decoded from fixed word 00 0000 0110 0100, one cycle.
// - decrement computes file value minus one; dest bit 0 writes W only.
// - decrement with dest bit 1 writes result back to the file register.
// - decrement updates only zero flag, set when result is zero.
// - decrement decoded by top bits 00 0011, bit 7 dest, 6..0 address.
module wdd_exec #(
    parameter PRESC_W = 8,
    parameter WDOG_W = 8
) (
    // apb clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // watchdog state toward the timeout path
    output reg [WDOG_W-1:0] watchdog_counter,
    output reg timeout_flag_n,
    output reg powerdown_flag_n
);

    function is_wclr;
        input [13:0] ins;
        begin
            is_wclr = (ins == `WDD_WCLR_CODE);
        end
    endfunction

    function is_fdec;
        input [13:0] ins;
        begin
            is_fdec = (ins[13:8] == `WDD_FDEC_HI);
        end
    endfunction

    function [7:0] dec8;
        input [7:0] v;
        begin
            dec8 = v - 8'h01;
        end
    endfunction

    reg [1:0] state;
    reg [13:0] last_instr;
    reg [7:0] wreg;
    reg carry;
    reg dcarry;
    reg zero;
    reg [PRESC_W-1:0] presc;
    reg [7:0] mem_q;
    reg [31:0] rd_val;
    reg [31:0] next_prdata;
    reg hit;

    // status reset pattern, split into its bits once
    localparam [4:0] ST_RST = `WDD_ST_RESET;

    wire [7:0] mem_rdata;
    wire access = psel & penable;
    wire commit = access & pready;
    wire mem_hit = (paddr[11:9] == `WDD_MEM_BASE_HI);
    wire [13:0] wr_instr = pwdata[13:0];
    wire instr_wr = pwrite & (paddr == `WDD_INSTR_OFS);
    wire fdec_wr = instr_wr & is_fdec(wr_instr);
    wire clr_wr = instr_wr & is_wclr(wr_instr);
    wire need_mem = (mem_hit & !pwrite) | fdec_wr;
    wire [7:0] dec_res = dec8(mem_q);
    // a decrement reads its operand through the same port as a bus read
    wire [6:0] rd_addr = fdec_wr ? wr_instr[6:0] : paddr[8:2];
    wire mem_we = commit & ((mem_hit & pwrite) | (fdec_wr & wr_instr[7]));
    wire [7:0] mem_wd = fdec_wr ? dec_res : pwdata[7:0];

    wdd_file_mem #(
        .DATA_W(8),
        .ADDR_W(7)
    ) u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(mem_we),
        .wr_addr(rd_addr),
        .wr_data(mem_wd),
        .rd_addr(rd_addr),
        .rd_data(mem_rdata)
    );

    always @* begin
        rd_val = 32'h00000000;
        hit = 1'b1;
        case (paddr)
            `WDD_INSTR_OFS: rd_val = {18'h00000, last_instr};
            `WDD_WREG_OFS: rd_val = {24'h000000, wreg};
            `WDD_STATUS_OFS: rd_val = {27'h0000000, timeout_flag_n,
                powerdown_flag_n, zero, dcarry, carry};
            `WDD_WDOG_OFS: rd_val = {{(32-WDOG_W){1'b0}}, watchdog_counter};
            `WDD_PRESC_OFS: rd_val = {{(32-PRESC_W){1'b0}}, presc};
            default: hit = mem_hit;
        endcase
        // writes return zero data so stale reads never leak
        if (pwrite) begin
            next_prdata = 32'h00000000;
        end else if (mem_hit) begin
            next_prdata = {24'h000000, mem_rdata};
        end else begin
            next_prdata = rd_val;
        end
    end

    // bus handshake; read data from memory costs one extra wait cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= `WDD_S_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            mem_q <= 8'h00;
        end else begin
            case (state)
                `WDD_S_IDLE: begin
                    if (access) begin
                        if (need_mem && hit) begin
                            state <= `WDD_S_FETCH;
                        end else begin
                            state <= `WDD_S_ANSWER;
                            pready <= 1'b1;
                            pslverr <= !hit;
                            prdata <= hit ? next_prdata : 32'h00000000;
                        end
                    end
                end
                `WDD_S_FETCH: begin
                    mem_q <= mem_rdata;
                    prdata <= next_prdata;
                    pslverr <= 1'b0;
                    pready <= 1'b1;
                    state <= `WDD_S_ANSWER;
                end
                `WDD_S_ANSWER: begin
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                    state <= `WDD_S_IDLE;
                end
                default: begin
                    pready <= 1'b0;
                    state <= `WDD_S_IDLE;
                end
            endcase
        end
    end

    // execution and register writes take effect on the completing edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_instr <= `WDD_INSTR_RESET;
            wreg <= 8'h00;
            carry <= ST_RST[`WDD_ST_CARRY];
            dcarry <= ST_RST[`WDD_ST_DCARRY];
            zero <= ST_RST[`WDD_ST_ZERO];
            powerdown_flag_n <= ST_RST[`WDD_ST_PDOWN_N];
            timeout_flag_n <= ST_RST[`WDD_ST_TOUT_N];
        end else if (commit && pwrite) begin
            if (paddr == `WDD_INSTR_OFS) begin
                last_instr <= wr_instr;
            end
            if (paddr == `WDD_WREG_OFS) begin
                wreg <= pwdata[7:0];
            end
            if (paddr == `WDD_STATUS_OFS) begin
                carry <= pwdata[`WDD_ST_CARRY];
                dcarry <= pwdata[`WDD_ST_DCARRY];
                zero <= pwdata[`WDD_ST_ZERO];
                powerdown_flag_n <= pwdata[`WDD_ST_PDOWN_N];
                timeout_flag_n <= pwdata[`WDD_ST_TOUT_N];
            end
            if (clr_wr) begin
                timeout_flag_n <= 1'b1;
                powerdown_flag_n <= 1'b1;
            end
            if (fdec_wr) begin
                zero <= (dec_res == 8'h00);
                if (!wr_instr[7]) begin
                    wreg <= dec_res;
                end
            end
        end
    end

    // free-running stand-in for the watchdog time base; clear wins over count
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc <= {PRESC_W{1'b0}};
            watchdog_counter <= {WDOG_W{1'b0}};
        end else if (commit && clr_wr) begin
            presc <= {PRESC_W{1'b0}};
            watchdog_counter <= {WDOG_W{1'b0}};
        end else begin
            presc <= presc + {{(PRESC_W-1){1'b0}}, 1'b1};
            if (&presc) begin
                watchdog_counter <= watchdog_counter +
                    {{(WDOG_W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule

`default_nettype wire

// [core/wdd_map.vh]
`ifndef WDD_MAP_VH
`define WDD_MAP_VH

// register byte offsets
`define WDD_INSTR_OFS 12'h000
`define WDD_WREG_OFS 12'h004
`define WDD_STATUS_OFS 12'h008
`define WDD_WDOG_OFS 12'h00c
`define WDD_PRESC_OFS 12'h010
// file memory window, 128 words of 4 bytes
`define WDD_MEM_BASE_HI 3'h1

// status field positions
`define WDD_ST_CARRY 0
`define WDD_ST_DCARRY 1
`define WDD_ST_ZERO 2
`define WDD_ST_PDOWN_N 3
`define WDD_ST_TOUT_N 4
`define WDD_ST_RESET 5'h18

// instruction encodings
`define WDD_WCLR_CODE 14'h0064
`define WDD_FDEC_HI 6'h03
`define WDD_INSTR_RESET 14'h0000

// state codes
`define WDD_S_IDLE 2'h0
`define WDD_S_FETCH 2'h1
`define WDD_S_ANSWER 2'h2

`endif

// [core/wdd_file_mem.v]
`default_nettype none

module wdd_file_mem #(
    parameter DATA_W = 8,
    parameter ADDR_W = 7
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // write port
    input wire wr_en,
    input wire [ADDR_W-1:0] wr_addr,
    input wire [DATA_W-1:0] wr_data,
    // read port, data one cycle after address
    input wire [ADDR_W-1:0] rd_addr,
    output reg [DATA_W-1:0] rd_data
);

    reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    always @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= {DATA_W{1'b0}};
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule

`default_nettype wire

// [testbench/wdd_exec_asserts.sv]
`default_nettype none
module wdd_exec_asserts #(
    parameter PRESC_W = 8,
    parameter WDOG_W = 8
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // watchdog
    input wire logic [WDOG_W-1:0] watchdog_counter,
    input wire logic timeout_flag_n,
    input wire logic powerdown_flag_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [WDOG_W-1:0] prev_cnt;
    wire done = psel && penable && pready && pwrite;
    wire clr = done && paddr == 12'h000 && pwdata[13:0] == 14'h0064;
    wire [WDOG_W-1:0] step = watchdog_counter - prev_cnt;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            prev_cnt <= '0;
        else
            prev_cnt <= watchdog_counter;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_CLR_ZERO: assert property (clr |=> watchdog_counter == '0)
        else $error("counter not zero after clear");
    AST_PRESC_CLR: assert property (
        clr |=> ##1 (watchdog_counter == '0) [*3])
        else $error("counter stepped too soon after clear");
    AST_CLR_FLAGS: assert property (
        clr |=> timeout_flag_n && powerdown_flag_n)
        else $error("flags not set by clear");
    // a jump other than +1 needs a clear one edge before
    AST_CNT_STEP: assert property (step > 1 |-> $past(clr))
        else $error("counter jumped without clear");
    AST_FLAG_HOLD: assert property (
        $changed({timeout_flag_n, powerdown_flag_n}) |->
        $past(done && paddr[11:4] == 8'h0 && paddr[2:0] == 3'h0))
        else $error("flags moved without status or instr write");
    AST_ANSWER: assert property (
        psel && penable && !pready |-> ##[1:2] pready)
        else $error("no answer in time");
    AST_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_WR_ZERO: assert property (
        pready && (pwrite || pslverr) |-> prdata == 32'h0)
        else $error("prdata not zero");
    cover property (clr);
    cover property (done && paddr == 12'h000 && pwdata[13:8] == 6'h03);
    cover property (pslverr);
endmodule
bind wdd_exec wdd_exec_asserts #(.PRESC_W(PRESC_W), .WDOG_W(WDOG_W)) i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .watchdog_counter(watchdog_counter),
    .timeout_flag_n(timeout_flag_n), .powerdown_flag_n(powerdown_flag_n));
`default_nettype wire

// [testbench/wdd_apb_master.sv]
`default_nettype none
module wdd_apb_master (
    // clock
    input wire logic pclk,
    // request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    // answer
    input wire logic pready
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        // released address and data lines show inverse, never the stale value
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn;
    wire psel, penable, pwrite, pready, pslverr, tout_n, pdown_n;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [7:0] wcnt;
    int checks, n_mismatch, seed = 68;
    logic [32:0] q[$];
    logic [32:0] exp_v;
    logic [7:0] v, w0, r;
    logic [6:0] f;
    logic [4:0] st;
    // short prescaler keeps the counter moving within the run
    wdd_exec #(.PRESC_W(3), .WDOG_W(8)) i_dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .watchdog_counter(wcnt),
        .timeout_flag_n(tout_n), .powerdown_flag_n(pdown_n));
    wdd_apb_master i_mst (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            exp_v = q.pop_front();
            `CHK({pslverr, prdata}, exp_v)
        end
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_mst.xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        q.push_back(e);
        i_mst.xfer(1'b0, a, 32'h0);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #20000;
        n_mismatch++;
        final_report();
    end
    initial begin
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (40) @(posedge pclk);
        wr(12'h008, 32'h0);
        wr(12'h000, 32'h0064);
        // pins update on the completing edge itself; sample them one edge later
        @(posedge pclk);
        `CHK({tout_n, pdown_n}, 2'b11)
        `CHK(wcnt, 8'h00)
        rd(12'h008, 33'h18);
        rd(12'h00c, 33'h0);
        $display("test clear done");
        wr(12'h008, 32'h0);
        wr(12'h000, 32'h0065);
        rd(12'h008, 33'h0);
        rd(12'h020, {1'b1, 32'h0});
        $display("test decode done");
        for (int i = 0; i < 8; i++) begin
            f = $random(seed);
            v = (i < 2) ? 8'(1 - i) : 8'($random(seed));
            w0 = $random(seed);
            st = $random(seed);
            r = v - 8'h1;
            wr({3'h1, f, 2'h0}, {24'h0, v});
            wr(12'h004, {24'h0, w0});
            wr(12'h008, {27'h0, st});
            wr(12'h000, {18'h0, 6'h03, i[0], f});
            rd(12'h004, {25'h0, i[0] ? w0 : r});
            rd({3'h1, f, 2'h0}, {25'h0, i[0] ? r : v});
            rd(12'h008, {28'h0, st[4:3], r == 8'h0, st[1:0]});
        end
        $display("test decrement done");
        final_report();
    end
endmodule
`default_nettype wire
